// ==== lvd_cfg.svh ====
// Offsets, field positions, reset values and timing counts for the low-voltage detect block.
`ifndef LVD_CFG_SVH
`define LVD_CFG_SVH

// ----------------------------------------------------------------------
// Register byte addresses.
// ----------------------------------------------------------------------
`define LVD_ADDR_CONTROL 4'h0
`define LVD_ADDR_STATUS 4'h4
`define LVD_ADDR_MASK 4'h8
`define LVD_ADDR_GLOBAL 4'hc

// ----------------------------------------------------------------------
// Field positions and values.
// ----------------------------------------------------------------------
`define LVD_BIT_LEVEL_LSB 0
`define LVD_BIT_LEVEL_MSB 3
`define LVD_BIT_ENABLE 4
`define LVD_BIT_STABLE 5
`define LVD_CONTROL_RESET 8'h05
`define LVD_LEVEL_EXTERNAL 4'hf
`define LVD_LEVEL_LOWEST 4'h2
`define LVD_RESP_OKAY 2'b00
`define LVD_RESP_SLVERR 2'b10

// ----------------------------------------------------------------------
// Timing: settle time in ns and clock period in ns.
// ----------------------------------------------------------------------
`define LVD_SETTLE_NS 20000
`define LVD_CLK_PERIOD_NS 20
`define LVD_SETTLE_CYCLES ((`LVD_SETTLE_NS + `LVD_CLK_PERIOD_NS - 1) / `LVD_CLK_PERIOD_NS)

`endif

// ==== lvd_pkg.sv ====
// Types shared by the low-voltage detect block.
package lvd_pkg;

    // Software-visible control fields.
    typedef struct packed {
        logic stable;
        logic enable;
        logic [3:0] level;
    } lvd_control_t;

    // Drive towards the analog comparator, reference and divider.
    typedef struct packed {
        logic power_en;
        logic ext_sel;
        logic [3:0] tap;
    } lvd_analog_t;

    // Detector sequencing states, one-hot.
    typedef enum logic [2:0] {
        LVD_OFF = 3'b001,
        LVD_SETTLE = 3'b010,
        LVD_READY = 3'b100
    } lvd_state_t;

endpackage

// ==== lvd_ctrl.sv ====
// Low-voltage detect control: AXI4-Lite registers, settle sequencing, trip flag, interrupt.
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "lvd_cfg.svh"

module lvd_ctrl
    import lvd_pkg::*;
#(
    parameter int SETTLE_CYCLES = `LVD_SETTLE_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    // AXI4-Lite write address channel.
    input wire logic [3:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data channel.
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response channel.
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address channel.
    input wire logic [3:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data channel.
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Comparator result: high while supply is at or below the trip point.
    input wire logic CMP_TRIP,
    // Drive to the analog macro.
    output lvd_analog_t ANALOG,
    // Level interrupt request towards the core.
    output logic IRQ,
    // Level wake request towards the sleep controller.
    output logic WAKE
);

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    localparam int CW = $clog2(SETTLE_CYCLES + 1);
    localparam logic [CW-1:0] SETTLE_LAST = CW'(SETTLE_CYCLES - 1);

    lvd_control_t ctrl_q; // Level and enable; stable is derived.
    lvd_state_t state_q; // Settle sequencer.
    lvd_state_t state_d;
    logic [CW-1:0] cnt_q; // Settle counter.
    logic [CW-1:0] cnt_d;
    logic flag_q; // Sticky low-voltage flag.
    logic flag_d;
    logic mask_q; // Detector interrupt enable.
    logic global_q; // Global interrupt enable.

    logic aw_held_q; // Write address captured.
    logic [3:0] aw_addr_q;
    logic w_held_q; // Write data captured.
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // ------------------------------------------------------------------
    // Bus handshakes and decode.
    // ------------------------------------------------------------------
    // Address and data are taken separately, in either order, and only
    // while no response is pending, so one write is in flight at a time.
    wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
    wire w_take = S_AXI_WVALID && S_AXI_WREADY;
    wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
    wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
    // Only byte lane 0 carries register bits.
    wire wr_lane0 = w_strb_q[0];
    wire wr_ctrl = wr_fire && (aw_addr_q == `LVD_ADDR_CONTROL);
    wire wr_mask = wr_fire && (aw_addr_q == `LVD_ADDR_MASK);
    wire wr_global = wr_fire && (aw_addr_q == `LVD_ADDR_GLOBAL);
    // The status register is read-only, so a write there is accepted.
    wire wr_stat = wr_fire && (aw_addr_q == `LVD_ADDR_STATUS);
    wire wr_hit = wr_ctrl || wr_mask || wr_global || wr_stat;
    wire rd_ctrl = (S_AXI_ARADDR == `LVD_ADDR_CONTROL);
    wire rd_stat = (S_AXI_ARADDR == `LVD_ADDR_STATUS);
    wire rd_mask = (S_AXI_ARADDR == `LVD_ADDR_MASK);
    wire rd_global = (S_AXI_ARADDR == `LVD_ADDR_GLOBAL);
    wire rd_hit = rd_ctrl || rd_stat || rd_mask || rd_global;
    wire stat_read = ar_take && rd_stat;

    assign S_AXI_AWREADY = !aw_held_q && !bvalid_q;
    assign S_AXI_WREADY = !w_held_q && !bvalid_q;
    assign S_AXI_ARREADY = !rvalid_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;

    // ------------------------------------------------------------------
    // Control field write and trip code mapping.
    // ------------------------------------------------------------------
    // The write applies enable and level together, so software that
    // changes the level with the enable set also restarts nothing.
    wire enable_new = w_data_q[`LVD_BIT_ENABLE];
    wire [3:0] level_new = w_data_q[`LVD_BIT_LEVEL_MSB:`LVD_BIT_LEVEL_LSB];
    wire stable = (state_q == LVD_READY);
    wire is_external = (ctrl_q.level == `LVD_LEVEL_EXTERNAL);
    // Reserved codes fold onto the lowest tap and never pick the pin.
    wire is_reserved = (ctrl_q.level < `LVD_LEVEL_LOWEST);
    // Tap codes rise with the trip voltage; the divider is monotonic.
    wire [3:0] tap_sel = is_reserved ? `LVD_LEVEL_LOWEST : ctrl_q.level;

    // One assignment for the whole struct keeps a single driver on the port.
    assign ANALOG = '{
        power_en: ctrl_q.enable,
        ext_sel: ctrl_q.enable && is_external,
        tap: tap_sel
    };

    // ------------------------------------------------------------------
    // Control register.
    // ------------------------------------------------------------------
    // Reset puts the detector off with the documented default level.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            // The two unimplemented top bits of the reset byte are cut off on purpose.
            ctrl_q <= lvd_control_t'(6'(`LVD_CONTROL_RESET));
        end else if (wr_ctrl && wr_lane0) begin
            ctrl_q.enable <= enable_new;
            ctrl_q.level <= level_new;
            ctrl_q.stable <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Settle sequencer.
    // ------------------------------------------------------------------
    // The reference needs a fixed time after each power-up. The counter
    // does not depend on the level code. Clearing the enable drops the
    // stable state one cycle later; any fresh enable begins a full wait again.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            LVD_OFF: begin
                // Start counting as soon as the macro is powered.
                cnt_d = '0;
                if (ctrl_q.enable) begin
                    state_d = LVD_SETTLE;
                end
            end
            LVD_SETTLE: begin
                if (!ctrl_q.enable) begin
                    state_d = LVD_OFF;
                end else if (cnt_q == SETTLE_LAST) begin
                    state_d = LVD_READY;
                end else begin
                    cnt_d = cnt_q + CW'(1);
                end
            end
            LVD_READY: begin
                if (!ctrl_q.enable) begin
                    state_d = LVD_OFF;
                end
            end
            default: begin
                state_d = LVD_OFF;
                cnt_d = '0;
            end
        endcase
        // A rewrite that sets enable from a cleared state restarts.
        if (wr_ctrl && wr_lane0 && enable_new && !ctrl_q.enable) begin
            state_d = LVD_SETTLE;
            cnt_d = '0;
        end
    end

    // State and counter flops.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= LVD_OFF;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Low-voltage flag.
    // ------------------------------------------------------------------
    // The comparator is only trusted once the reference is stable, so
    // short dips during the settle wait go unseen. A trip in the same
    // cycle as a clearing status read keeps the flag set. There is no
    // clock gating here: the block keeps detecting through sleep.
    wire trip_event = ctrl_q.enable && stable && CMP_TRIP;
    always_comb begin
        flag_d = flag_q;
        if (stat_read) begin
            flag_d = 1'b0;
        end
        if (trip_event) begin
            flag_d = 1'b1;
        end
    end

    // Flag flop.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt enables and outputs.
    // ------------------------------------------------------------------
    // Mask and global enable registers.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            mask_q <= 1'b0;
            global_q <= 1'b0;
        end else begin
            if (wr_mask && wr_lane0) begin
                mask_q <= w_data_q[0];
            end
            if (wr_global && wr_lane0) begin
                global_q <= w_data_q[0];
            end
        end
    end

    // The request needs both enables; wake needs only the detector one,
    // matching a core that resumes even with interrupts globally off.
    assign IRQ = flag_q && mask_q && global_q;
    assign WAKE = flag_q && mask_q;

    // ------------------------------------------------------------------
    // Write channel capture and response.
    // ------------------------------------------------------------------
    // Captured address and data wait until both halves are present.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
            w_held_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else begin
            if (aw_take) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            if (w_take) begin
                w_held_q <= 1'b1;
                w_data_q <= S_AXI_WDATA;
                w_strb_q <= S_AXI_WSTRB;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Response follows the applied write; unmapped words get SLVERR.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            bvalid_q <= 1'b0;
            bresp_q <= `LVD_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? `LVD_RESP_OKAY : `LVD_RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read channel.
    // ------------------------------------------------------------------
    // Read data are assembled from live state; upper bits read zero.
    logic [31:0] rd_word;
    always_comb begin
        rd_word = '0;
        if (rd_ctrl) begin
            rd_word[`LVD_BIT_LEVEL_MSB:`LVD_BIT_LEVEL_LSB] = ctrl_q.level;
            rd_word[`LVD_BIT_ENABLE] = ctrl_q.enable;
            rd_word[`LVD_BIT_STABLE] = stable;
        end else if (rd_stat) begin
            rd_word[0] = flag_q;
        end else if (rd_mask) begin
            rd_word[0] = mask_q;
        end else if (rd_global) begin
            rd_word[0] = global_q;
        end
    end

    // One read at a time; data and response register on the take.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `LVD_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? `LVD_RESP_OKAY : `LVD_RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule

// ==== lvd_ctrl_assertions.sv ====
// Port-level checks for the low-voltage detect control block.
`timescale 1ns/10ps
module lvd_ctrl_assertions
    import lvd_pkg::*;
#(
    parameter int SETTLE_CYCLES = 8
) (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire lvd_analog_t ANALOG,
    input wire logic IRQ,
    input wire logic WAKE
);
    // ----
    // Powered-cycle counter
    // ----
    // Saturates so a long powered spell never wraps back into the settle window.
    logic [15:0] on_q;
    default clocking @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESETN);
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            on_q <= 16'h0000;
        end else begin
            on_q <= ANALOG.power_en ? on_q + {15'h0000, ~&on_q} : 16'h0000;
        end
    end
    // ----
    // Properties
    // ----
    AST_EXT_SEL: assert property (ANALOG.ext_sel |-> ANALOG.power_en && ANALOG.tap == 4'hf)
        else $error("External input picked while off or on another code.");
    AST_TAP_FLOOR: assert property (ANALOG.tap >= 4'h2)
        else $error("A reserved code reached the divider.");
    AST_IRQ_GATED: assert property (IRQ |-> WAKE)
        else $error("Interrupt raised without an enabled flag.");
    AST_NO_EARLY: assert property (on_q < SETTLE_CYCLES |-> !$rose(WAKE))
        else $error("Flag set while off or before the reference settled.");
    AST_RESET_OFF: assert property (disable iff (1'b0) !RESETN |-> !ANALOG.power_en)
        else $error("Detector powered during reset.");
    AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("Write response dropped early.");
    AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("Read data dropped early.");
    AST_B_CODE: assert property (S_AXI_BVALID |-> S_AXI_BRESP inside {2'b00, 2'b10})
        else $error("Unexpected write response code.");
    CV_IRQ: cover property ($rose(IRQ));
    CV_EXT: cover property ($rose(ANALOG.ext_sel));
    CV_ERR: cover property (S_AXI_BVALID && S_AXI_BRESP == 2'b10);
endmodule

// ==== lvd_cmp_model.sv ====
// Behavioural comparator, reference and divider facing the detector control.
`timescale 1ns/10ps
module lvd_cmp_model
    import lvd_pkg::*;
(
    input wire logic clk,
    input wire lvd_analog_t analog,
    input wire logic [3:0] supply,
    input wire logic ext_low,
    output logic trip
);
    // An unpowered comparator output is meaningless, so it wanders every cycle.
    logic idle_q = 1'b0;
    always @(posedge clk) begin
        idle_q <= !idle_q;
    end
    // Supply is on the tap scale: a higher tap trips at a higher supply.
    assign trip = !analog.power_en ? idle_q : analog.ext_sel ? ext_low : supply <= analog.tap;
endmodule

// ==== test_low_voltage_detect_control.sv ====
// Self-checking bench for the low-voltage detect control block.
`timescale 1ns/10ps
module test_low_voltage_detect_control import lvd_pkg::*;;
    localparam int SC = 8;
    logic core_clk = 1'b0;
    logic resetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
    logic awready, wready, arready, irq, wake, trip, ext_low;
    logic [3:0] awaddr, araddr, wstrb, supply;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    lvd_analog_t analog;
    int failures = 0;
    int n_compared = 0;

    always #10 core_clk = ~core_clk;

    lvd_ctrl #(.SETTLE_CYCLES(SC)) i_dut (
        .CORE_CLK(core_clk), .RESETN(resetn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .CMP_TRIP(trip), .ANALOG(analog), .IRQ(irq), .WAKE(wake));
    lvd_cmp_model u_cmp (.clk(core_clk), .analog(analog), .supply(supply),
        .ext_low(ext_low), .trip(trip));

    // ----
    // Reporting
    // ----
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic expire();
        failures++;
        final_report();
    endtask

    // ----
    // Bus cycles
    // ----
    // Unaligned addresses are unmapped and must answer with an error code.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bit done;
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                done = 1'b1;
                bready <= 1'b0;
                chk("bresp", 32'(bresp), {30'h0, a[1:0] != 2'b00, 1'b0});
            end
        end
        if (!done) expire();
        @(posedge core_clk);
    endtask

    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        bit done;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                done = 1'b1;
                rready <= 1'b0;
                chk("rresp", 32'(rresp), {30'h0, a[1:0] != 2'b00, 1'b0});
                chk($sformatf("reg %h", a), rdata, exp);
            end
        end
        if (!done) expire();
        @(posedge core_clk);
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_stable_ro();
        rdc(4'h0, 32'h05);
        chk("analog", 32'(analog), 32'h05);
        wr(4'h0, 32'h3f);
        rdc(4'h0, 32'h1f);
        chk("analog", 32'(analog), 32'h3f);
        wr(4'h0, 32'h0f);
        chk("analog", 32'(analog), 32'h0f);
    endtask

    task automatic t_levels();
        for (int c = 0; c < 16; c++) begin
            wr(4'h0, 32'h10 | c);
            chk("analog", 32'(analog), {27'h1, c == 15, (c < 2) ? 4'h2 : 4'(c)});
        end
        wr(4'h0, 32'h00);
        chk("power", 32'(analog.power_en), 32'h0);
    endtask

    // Follows the documented setup order with the supply already below the trip point.
    task automatic t_trip();
        int n;
        supply <= 4'h3;
        wr(4'h0, 32'h00);
        wr(4'h0, 32'h04);
        wr(4'h0, 32'h14);
        rdc(4'h0, 32'h14);
        rdc(4'h4, 32'h0);
        wr(4'h8, 32'h1);
        n = 0;
        while (!wake && n < 40) begin
            @(posedge core_clk);
            n++;
        end
        chk("wake", 32'(wake), 32'h1);
        chk("irq", 32'(irq), 32'h0);
        rdc(4'h0, 32'h34);
        wr(4'hc, 32'h1);
        chk("irq", 32'(irq), 32'h1);
        wr(4'h8, 32'h0);
        chk("irq", {30'h0, irq, wake}, 32'h0);
        wr(4'h8, 32'h1);
        supply <= 4'hf;
        rdc(4'h4, 32'h1);
        rdc(4'h4, 32'h0);
        wr(4'h0, 32'h04);
        rdc(4'h0, 32'h04);
        wr(4'h0, 32'h14);
        rdc(4'h0, 32'h14);
        repeat (SC + 4) @(posedge core_clk);
        rdc(4'h0, 32'h34);
        wr(4'h0, 32'h04);
    endtask

    // The pin path trips only under the external code; a first read clears stragglers and a second reads clear.
    task automatic t_external();
        ext_low <= 1'b1;
        wr(4'h0, 32'h1f);
        repeat (SC + 4) @(posedge core_clk);
        chk("wake", 32'(wake), 32'h1);
        ext_low <= 1'b0;
        rdc(4'h4, 32'h1);
        ext_low <= 1'b1;
        wr(4'h0, 32'h1e);
        rdc(4'h4, 32'h1);
        rdc(4'h4, 32'h0);
        wr(4'h0, 32'h0e);
    endtask

    task automatic t_refused();
        wr(4'h2, 32'h1f);
        rdc(4'h2, 32'h0);
        wstrb <= 4'h0;
        wr(4'h0, 32'h1f);
        wstrb <= 4'hf;
        rdc(4'h0, 32'h0e);
    endtask

    task automatic t_reset_mid();
        wr(4'h0, 32'h1f);
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("analog", 32'(analog), 32'h05);
        resetn <= 1'b1;
        @(posedge core_clk);
        rdc(4'h0, 32'h05);
    endtask

    initial begin
        // Start high so that the drop below is a real falling edge, seen by
        // every asynchronous reset before the first clock edge arrives.
        resetn = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, ext_low} = 6'h00;
        {awaddr, araddr, wstrb, supply} = 16'h00ff;
        wdata = 32'h0;
        #1;
        resetn = 1'b0;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        t_stable_ro();
        t_levels();
        t_trip();
        t_external();
        t_refused();
        t_reset_mid();
        final_report();
    end
endmodule

bind lvd_ctrl lvd_ctrl_assertions #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .ANALOG(ANALOG),
    .IRQ(IRQ), .WAKE(WAKE));
